/* File: rtl/escc_pkg.sv */
// What this block does
// - Shadow-use bit 12 set: run from shadow words, ignore NVM contents.
// - Shadow-use set: bus reads of configuration locations return shadow contents.
// - Reload bit 8 written 1 copies NVM contents into shadow words.
// - Write-enable bit 2 behaves exactly like the reload bit.
// - Access select: 00 off, 01 single-location access, 10 mass access.
// - Single-read register shows the word fetched by the last single read.
// - Addresses 0x37-0x5F and 0x61-0x8F do nothing.
// - Inhibit bit 15 at 0x60 stops motor control without sleep.
// - Inhibit bit is write-only; reads never return it.
// - Bits 15:14 of word 1 select spread-spectrum dithering.
// - Bits 13:12 choose in which loop phases tach pulses appear.
// - Tach rate is electrical rate divided by divider field plus one.
// - Bit 7 selects full-cycle (0) or half-cycle (1) clock adjust.
// - Phase resistance is mantissa 3:0 shifted left by count 6:4.
// - Word 1 lives at 0x90; writes go to its shadow word, reads follow shadow use; resets to zero.
// - Single-access address picks the NVM location of single reads and writes.
// - Ready flag shows NVM idle; host waits for it before access.
// - Single write-data register supplies the word written to NVM.
package escc_pkg;
  localparam int DATA_W = 16;
  localparam int BYTE_BITS = 8;
  localparam int NVM_WORDS = 7;
  // Register map
  localparam logic [7:0] A_KEY = 8'h31;
  localparam logic [7:0] A_READY = 8'h32;
  localparam logic [7:0] A_IND_ADDR = 8'h33;
  localparam logic [7:0] A_IND_WDATA = 8'h34;
  localparam logic [7:0] A_ACC_CTRL = 8'h35;
  localparam logic [7:0] A_IND_RDATA = 8'h36;
  localparam logic [7:0] A_CTRL = 8'h60;
  localparam logic [7:0] A_CFG_FIRST = 8'h90;
  localparam logic [7:0] A_CFG_LAST = 8'h96;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] UNLOCK_KEY = 16'hc0de;
  // Access control fields
  localparam int B_SHADOW = 12;
  localparam int B_RELOAD = 8;
  localparam int B_WREN = 2;
  localparam int B_ACC_HI = 1;
  localparam int B_ACC_LO = 0;
  localparam int B_INHIBIT = 15;
  // Configuration word 1 fields
  localparam int C_SS_HI = 15;
  localparam int C_SS_LO = 14;
  localparam int C_OL_HI = 13;
  localparam int C_OL_LO = 12;
  localparam int C_DIV_HI = 11;
  localparam int C_DIV_LO = 8;
  localparam int C_ADJ = 7;
  localparam int C_SH_HI = 6;
  localparam int C_SH_LO = 4;
  localparam int C_MAN_HI = 3;
  localparam int C_MAN_LO = 0;
  localparam int RES_W = 11;
  typedef enum logic [1:0] {ACC_OFF = 2'h0, ACC_SINGLE = 2'h1, ACC_MASS = 2'h2, ACC_BAD = 2'h3} escc_acc_t;
  typedef enum logic [1:0] {OL_BOTH = 2'h0, OL_CLOSED = 2'h1, OL_FIRST = 2'h2, OL_RSVD = 2'h3} escc_ol_t;
  // NVM operation time
  localparam int CLK_PERIOD_NS = 4;
  localparam int NVM_OP_NS = 1000;
  localparam int NVM_OP_CYCLES = (NVM_OP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_W = $clog2(NVM_OP_CYCLES + 1);
  typedef enum logic [2:0] {S_IDLE, S_DEV, S_REG, S_WR, S_ACK, S_RD, S_MACK} escc_bus_st_t;
  typedef enum logic [2:0] {OP_NONE, OP_READ, OP_WRITE, OP_MASS, OP_RELOAD} escc_op_t;
endpackage

/* File: rtl/escc_tach_gen.sv */
`timescale 1ns/1ps
module escc_tach_gen
  import escc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Settings and motor events
  escc_tach_if.gen t
);
  typedef struct packed {
    logic [3:0] cnt;
    logic seen_closed;
    logic pulse;
  } escc_tach_st_t;

  escc_tach_st_t r_reg;
  escc_tach_st_t r_next;

  // Pulse counter; the first open loop is the one before any closed loop
  always_comb begin
    logic allow;
    allow = 1'b0;
    r_next = r_reg;
    r_next.pulse = 1'b0;
    if (t.closed_loop) begin
      r_next.seen_closed = 1'b1;
    end
    case (t.openloop_sel)
      OL_BOTH: allow = 1'b1;
      OL_CLOSED: allow = t.closed_loop;
      OL_FIRST: allow = t.closed_loop || !r_reg.seen_closed;
      default: allow = t.closed_loop; // Reserved code acts as closed loop only
    endcase
    if (t.elec_pulse && allow) begin
      if (r_reg.cnt >= t.divider) begin
        r_next.cnt = '0;
        r_next.pulse = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign t.tach_pulse = r_reg.pulse;
endmodule

/* File: rtl/escc_tach_if.sv */
`timescale 1ns/1ps
interface escc_tach_if;
  logic [3:0] divider;
  logic [1:0] openloop_sel;
  logic elec_pulse;
  logic closed_loop;
  logic tach_pulse;
  modport cfg (output divider, output openloop_sel, output elec_pulse, output closed_loop, input tach_pulse);
  modport gen (input divider, input openloop_sel, input elec_pulse, input closed_loop, output tach_pulse);
endinterface

/* File: rtl/escc_top.sv */
`timescale 1ns/1ps
module escc_top
  import escc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h52 // Arbitrary bus address
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Two-wire host bus, open drain data
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Motor events
  input wire logic elec_pulse,
  input wire logic closed_loop,
  // Configuration towards the motor control
  output logic motor_drive_inhibit,
  output logic [1:0] spread_spectrum_select,
  output logic cycle_adjust_select,
  output logic [RES_W-1:0] phase_resistance,
  output logic tach_output
);
  localparam int IW = $clog2(NVM_WORDS);

  // All state in one record: bus engine, register file, NVM image and shadow words
  typedef struct packed {
    escc_bus_st_t bus_st;
    escc_bus_st_t ack_next;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [7:0] ptr;
    logic hi_done;
    logic [7:0] wbuf;
    logic [15:0] rbuf;
    logic [7:0] tx;
    logic scl_q;
    logic sda_q;
    logic sda_oe;
    logic [15:0] key;
    logic [7:0] ind_addr;
    logic [15:0] ind_wdata;
    logic [15:0] ind_rdata;
    logic shadow_use;
    logic reload_req;
    logic wr_en;
    logic [1:0] acc_sel;
    logic inhibit;
    escc_op_t op;
    logic [BUSY_W-1:0] busy_cnt;
    logic [NVM_WORDS-1:0][15:0] nvm;
    logic [NVM_WORDS-1:0][15:0] shadow;
    logic [1:0] ss;
    logic adj;
    logic [RES_W-1:0] res;
    logic [3:0] tdiv;
    logic [1:0] tsel;
  } escc_st_t;

  escc_st_t r_reg;
  escc_st_t r_next;
  // Tach settings and events travel to the divider through one interface
  escc_tach_if tif ();

  // Configuration address window check
  function automatic logic in_cfg(input logic [7:0] a);
    return (a >= A_CFG_FIRST) && (a <= A_CFG_LAST);
  endfunction

  // Word index inside the configuration window; callers check the window first
  function automatic logic [IW-1:0] cfg_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - A_CFG_FIRST;
    return d[IW-1:0];
  endfunction

  // Read view of every location; unknown addresses answer zero
  // Reads have no side effects, so a polled register may be read at any time
  function automatic logic [15:0] read_word(input escc_st_t s, input logic [7:0] a);
    logic [15:0] v;
    v = RESET_WORD;
    case (a)
      A_KEY: v = s.key;
      A_READY: v[0] = (s.op == OP_NONE);
      A_IND_ADDR: v[7:0] = s.ind_addr;
      A_IND_WDATA: v = s.ind_wdata;
      A_ACC_CTRL: begin
        v[B_SHADOW] = s.shadow_use;
        v[B_RELOAD] = s.reload_req;
        v[B_WREN] = s.wr_en;
        v[B_ACC_HI:B_ACC_LO] = s.acc_sel;
      end
      A_IND_RDATA: v = s.ind_rdata;
      A_CTRL: v = RESET_WORD;
      default: begin
        if (in_cfg(a)) begin
          v = s.shadow_use ? s.shadow[cfg_idx(a)] : s.nvm[cfg_idx(a)];
        end else begin
          v = RESET_WORD;
        end
      end
    endcase
    return v;
  endfunction

  // Bus engine, NVM sequencer and register file in one next-state process
  always_comb begin
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic wr_go;
    logic key_ok;
    logic op_free;
    logic [15:0] wd;
    logic [15:0] rd;
    logic [15:0] cfg;
    start = 1'b0;
    stop = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    wr_go = 1'b0;
    key_ok = 1'b0;
    op_free = 1'b0;
    wd = RESET_WORD;
    rd = RESET_WORD;
    cfg = RESET_WORD;
    r_next = r_reg;
    r_next.scl_q = scl;
    r_next.sda_q = sda_in;
    // Edges and bus conditions against the samples of the previous cycle
    rise = scl && !r_reg.scl_q;
    fall = !scl && r_reg.scl_q;
    start = scl && r_reg.scl_q && r_reg.sda_q && !sda_in;
    stop = scl && r_reg.scl_q && !r_reg.sda_q && sda_in;

    // Serial bus: bits sampled on rising clock, data changed on falling clock
    // A start may arrive in any state, so it overrides the byte engine
    if (start) begin
      r_next.bus_st = S_DEV;
      r_next.cnt = '0;
      r_next.sda_oe = 1'b0;
    end else if (stop) begin
      r_next.bus_st = S_IDLE;
      r_next.sda_oe = 1'b0;
    end else begin
      case (r_reg.bus_st)
        S_DEV, S_REG, S_WR: begin
          if (rise) begin
            r_next.sh = {r_reg.sh[6:0], sda_in};
            r_next.cnt = r_reg.cnt + 4'h1;
          end else if (fall && r_reg.cnt == 4'(BYTE_BITS)) begin
            r_next.cnt = '0;
            r_next.sda_oe = 1'b1;
            r_next.bus_st = S_ACK;
            r_next.ack_next = S_WR;
            if (r_reg.bus_st == S_DEV) begin
              if (r_reg.sh[7:1] != DEV_ADDR) begin
                // Another device is addressed: stay off the line until the next start
                r_next.sda_oe = 1'b0;
                r_next.bus_st = S_IDLE;
              end else if (r_reg.sh[0]) begin
                r_next.ack_next = S_RD;
                r_next.rbuf = read_word(r_reg, r_reg.ptr);
                r_next.hi_done = 1'b0;
              end else begin
                r_next.ack_next = S_REG;
              end
            end else if (r_reg.bus_st == S_REG) begin
              r_next.ptr = r_reg.sh;
              r_next.hi_done = 1'b0;
            end else if (!r_reg.hi_done) begin
              r_next.wbuf = r_reg.sh;
              r_next.hi_done = 1'b1;
            end else begin
              // Word completes on its low byte; pointer moves to the next location
              wr_go = 1'b1;
              wd = {r_reg.wbuf, r_reg.sh};
              r_next.ptr = r_reg.ptr + 8'h01;
              r_next.hi_done = 1'b0;
            end
          end
        end
        S_ACK: begin
          // Acknowledge ends; a read puts its first data bit out at once
          if (fall) begin
            r_next.sda_oe = 1'b0;
            r_next.bus_st = r_reg.ack_next;
            if (r_reg.ack_next == S_RD) begin
              r_next.sda_oe = !r_reg.rbuf[15];
              r_next.tx = {r_reg.rbuf[14:8], 1'b0};
              r_next.cnt = 4'h1;
            end
          end
        end
        S_RD: begin
          // Eight bits out, then the line is freed for the host's answer
          if (fall) begin
            if (r_reg.cnt == 4'(BYTE_BITS)) begin
              r_next.sda_oe = 1'b0;
              r_next.bus_st = S_MACK;
            end else begin
              r_next.sda_oe = !r_reg.tx[7];
              r_next.tx = {r_reg.tx[6:0], 1'b0};
              r_next.cnt = r_reg.cnt + 4'h1;
            end
          end
        end
        S_MACK: begin
          // Host answer slot: low asks for the next byte, high ends the read
          if (rise && sda_in) begin
            r_next.bus_st = S_IDLE; // Host declined more data
          end else if (fall) begin
            r_next.bus_st = S_RD;
            r_next.cnt = 4'h1;
            if (!r_reg.hi_done) begin
              r_next.hi_done = 1'b1;
              r_next.sda_oe = !r_reg.rbuf[7];
              r_next.tx = {r_reg.rbuf[6:0], 1'b0};
            end else begin
              rd = read_word(r_reg, r_reg.ptr + 8'h01);
              r_next.hi_done = 1'b0;
              r_next.ptr = r_reg.ptr + 8'h01;
              r_next.rbuf = rd;
              r_next.sda_oe = !rd[15];
              r_next.tx = {rd[14:8], 1'b0};
            end
          end
        end
        default: r_next.bus_st = S_IDLE;
      endcase
    end

    // NVM sequencer; busy time keeps the ready flag low
    // Limitation: a started operation cannot be aborted; the host must poll ready
    if (r_reg.op != OP_NONE) begin
      if (r_reg.busy_cnt != '0) begin
        r_next.busy_cnt = r_reg.busy_cnt - 1'b1;
      end else begin
        r_next.op = OP_NONE;
        case (r_reg.op)
          OP_READ: r_next.ind_rdata = in_cfg(r_reg.ind_addr) ? r_reg.nvm[cfg_idx(r_reg.ind_addr)] : RESET_WORD;
          OP_WRITE: begin
            if (in_cfg(r_reg.ind_addr)) begin
              r_next.nvm[cfg_idx(r_reg.ind_addr)] = r_reg.ind_wdata;
            end
          end
          // Mass access copies every shadow word into the NVM image in one step
          OP_MASS: r_next.nvm = r_reg.shadow;
          OP_RELOAD: begin
            // Bit 2 repeats the reload action; it was most likely meant as a write enable
            r_next.shadow = r_reg.nvm;
            r_next.reload_req = 1'b0;
            r_next.wr_en = 1'b0;
          end
          default: r_next.op = OP_NONE;
        endcase
      end
    end else if (r_reg.reload_req || r_reg.wr_en) begin
      r_next.op = OP_RELOAD;
      r_next.busy_cnt = BUSY_W'(NVM_OP_CYCLES - 1);
    end

    // Register writes; a single or mass request while busy is stored but starts no operation
    // Single and mass operations need the unlock key and an idle sequencer
    key_ok = (r_reg.key == UNLOCK_KEY);
    op_free = (r_reg.op == OP_NONE) && (r_next.op == OP_NONE);
    if (wr_go) begin
      case (r_reg.ptr)
        A_KEY: r_next.key = wd;
        A_IND_ADDR: begin
          r_next.ind_addr = wd[7:0];
          if (r_reg.acc_sel == ACC_SINGLE && key_ok && op_free) begin
            r_next.op = OP_READ;
            r_next.busy_cnt = BUSY_W'(NVM_OP_CYCLES - 1);
          end
        end
        A_IND_WDATA: begin
          r_next.ind_wdata = wd;
          if (r_reg.acc_sel == ACC_SINGLE && key_ok && op_free) begin
            r_next.op = OP_WRITE;
            r_next.busy_cnt = BUSY_W'(NVM_OP_CYCLES - 1);
          end
        end
        A_ACC_CTRL: begin
          r_next.shadow_use = wd[B_SHADOW];
          r_next.reload_req = wd[B_RELOAD] || (r_reg.reload_req && r_reg.op != OP_RELOAD);
          r_next.wr_en = wd[B_WREN] || (r_reg.wr_en && r_reg.op != OP_RELOAD);
          // Select 11 is stored as written but starts no operation
          r_next.acc_sel = wd[B_ACC_HI:B_ACC_LO];
          if (wd[B_ACC_HI:B_ACC_LO] == ACC_MASS && key_ok && op_free) begin
            r_next.op = OP_MASS;
            r_next.busy_cnt = BUSY_W'(NVM_OP_CYCLES - 1);
          end
        end
        A_CTRL: r_next.inhibit = wd[B_INHIBIT];
        default: begin
          if (in_cfg(r_reg.ptr)) begin
            r_next.shadow[cfg_idx(r_reg.ptr)] = wd;
          end
        end
      endcase
    end

    // Active configuration; shadow overrides NVM when selected
    // Only word 0 drives the motor; the other words are stored for the host
    // Registering costs a cycle of latency but keeps the settings glitch free
    cfg = r_reg.shadow_use ? r_reg.shadow[0] : r_reg.nvm[0];
    r_next.ss = cfg[C_SS_HI:C_SS_LO];
    r_next.adj = cfg[C_ADJ];
    r_next.res = RES_W'(cfg[C_MAN_HI:C_MAN_LO]) << cfg[C_SH_HI:C_SH_LO];
    r_next.tdiv = cfg[C_DIV_HI:C_DIV_LO];
    r_next.tsel = cfg[C_OL_HI:C_OL_LO];
  end

  // Every field but the line history, NVM image included, clears to zero at reset
  // Line history starts idle high so no false start follows reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.scl_q <= 1'b1;
      r_reg.sda_q <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Tach divider fed from registered settings
  assign tif.divider = r_reg.tdiv;
  assign tif.openloop_sel = r_reg.tsel;
  assign tif.elec_pulse = elec_pulse;
  assign tif.closed_loop = closed_loop;

  escc_tach_gen u_tach (
    .mclk(mclk),
    .rst_n(rst_n),
    .t(tif.gen)
  );

  // Open drain: the line is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe = r_reg.sda_oe;

  // Settings leave straight from their registers
  assign motor_drive_inhibit = r_reg.inhibit;
  assign spread_spectrum_select = r_reg.ss;
  assign cycle_adjust_select = r_reg.adj;
  assign phase_resistance = r_reg.res;
  assign tach_output = tif.tach_pulse;
endmodule

/* File: tb/escc_checker.sv */
`timescale 1ns/1ps
module escc_checker
  import escc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bus
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Motor side
  input wire logic elec_pulse,
  input wire logic closed_loop,
  input wire logic motor_drive_inhibit,
  input wire logic [1:0] spread_spectrum_select,
  input wire logic cycle_adjust_select,
  input wire logic [RES_W-1:0] phase_resistance,
  input wire logic tach_output
);
  logic scl_q;
  logic [8:0] quiet_cnt;
  logic [3:0] fall_cnt;
  // Settings may only move shortly after bus traffic, so count quiet cycles
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      quiet_cnt <= 9'h000;
      fall_cnt <= 4'h0;
    end else begin
      scl_q <= scl;
      quiet_cnt <= (scl != scl_q) ? 9'h000 : quiet_cnt + {8'h00, quiet_cnt != 9'h1ff};
      fall_cnt <= (scl_q && !scl) ? 4'h0 : fall_cnt + {3'h0, fall_cnt != 4'hf};
    end
  end
  // A legal value is a four-bit mantissa moved left by some count
  function automatic logic res_ok(input logic [RES_W-1:0] p);
    res_ok = 1'b0;
    for (int s = 0; s < 8; s++) begin
      if (p == (((p >> s) & 11'h00f) << s)) begin
        res_ok = 1'b1;
      end
    end
  endfunction
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence scl_high_two;
    scl ##1 scl;
  endsequence
  sequence pulse_then_tach;
    elec_pulse ##1 tach_output;
  endsequence
  reset_zero_a: assert property ($rose(rst_n) |-> !motor_drive_inhibit && !cycle_adjust_select
    && spread_spectrum_select == 2'h0 && phase_resistance == 11'h000 && !tach_output) else $error("outputs not zero");
  tach_cause_a: assert property (tach_output |-> $past(elec_pulse))
    else $error("tach pulse without electrical pulse");
  res_form_a: assert property (res_ok(phase_resistance))
    else $error("resistance not mantissa shifted");
  res_quiet_a: assert property ($changed(phase_resistance) |-> quiet_cnt < 9'h12c)
    else $error("resistance changed without bus cause");
  spread_quiet_a: assert property ($changed(spread_spectrum_select) |-> quiet_cnt < 9'h12c)
    else $error("spread select changed without bus cause");
  adjust_quiet_a: assert property ($changed(cycle_adjust_select) |-> quiet_cnt < 9'h12c)
    else $error("cycle adjust changed without bus cause");
  inhibit_load_a: assert property ($changed(motor_drive_inhibit) |-> fall_cnt < 4'h6)
    else $error("inhibit changed away from a word end");
  data_hold_a: assert property (scl_high_two |-> $stable(sda_oe))
    else $error("data pulled while bus clock high");
  data_launch_a: assert property ($rose(sda_oe) |-> !scl)
    else $error("data pulled while bus clock high");
  drain_low_a: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  tach_seen_c: cover property (pulse_then_tach);
endmodule

bind escc_top escc_checker i_escc_checker (.mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .elec_pulse(elec_pulse), .closed_loop(closed_loop),
  .motor_drive_inhibit(motor_drive_inhibit), .spread_spectrum_select(spread_spectrum_select),
  .cycle_adjust_select(cycle_adjust_select), .phase_resistance(phase_resistance), .tach_output(tach_output));

/* File: tb/escc_host_model.sv */
`timescale 1ns/1ps
module escc_host_model
  import escc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h52 // Arbitrary bus address
) (
  // Clock
  input wire logic mclk,
  // Bus wire
  output logic scl,
  output logic sda_drv,
  input wire logic sda_in
);
  // Both lines idle high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Four cycles a phase keeps well clear of the two-cycle minimum
  task automatic ph();
    repeat (4) @(posedge mclk);
  endtask
  // Data moves one cycle after the clock falls, never alongside it
  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    ph();
    scl <= 1'b1;
    ph();
    r = sda_in;
    scl <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic start();
    sda_drv <= 1'b1;
    ph();
    scl <= 1'b1;
    ph();
    sda_drv <= 1'b0;
    ph();
    scl <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    ph();
    scl <= 1'b1;
    ph();
    sda_drv <= 1'b1;
    ph();
  endtask
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(last, a);
  endtask
  // Whole word, high byte first
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    logic [7:0] r;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, r);
    xfer(a, 1'b1, r);
    xfer(d[15:8], 1'b1, r);
    xfer(d[7:0], 1'b1, r);
    stop();
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    logic [7:0] r;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, r);
    xfer(a, 1'b1, r);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, r);
    xfer(8'hff, 1'b0, d[15:8]);
    xfer(8'hff, 1'b1, d[7:0]); // Last byte refused to end the read
    stop();
  endtask
endmodule

/* File: tb/escc_top_tb.sv */
`timescale 1ns/1ps
module escc_top_tb;
  import escc_pkg::*;
  localparam logic [6:0] BUS_ADDR = 7'h52; // Arbitrary bus address
  logic mclk;
  logic rst_n;
  logic scl;
  logic sda_drv;
  logic sda_out;
  logic sda_oe;
  logic sda_wire;
  logic elec_pulse;
  logic closed_loop;
  logic motor_drive_inhibit;
  logic [1:0] spread_spectrum_select;
  logic cycle_adjust_select;
  logic [RES_W-1:0] phase_resistance;
  logic tach_output;
  logic [15:0] rd;
  logic [15:0] cfg_w [4] = '{16'h0079, 16'h45af, 16'h9e3c, 16'hf0ff};
  logic [7:0] unused_a [4] = '{8'h37, 8'h5f, 8'h61, 8'h8f};
  int num_errors;
  int n_tests;
  int tach_cnt = 0;
  // Pulled-up data line, low while either side pulls
  assign sda_wire = sda_drv & (sda_out | ~sda_oe);
  escc_top #(.DEV_ADDR(BUS_ADDR)) i_escc_top (.mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .elec_pulse(elec_pulse), .closed_loop(closed_loop),
    .motor_drive_inhibit(motor_drive_inhibit), .spread_spectrum_select(spread_spectrum_select),
    .cycle_adjust_select(cycle_adjust_select), .phase_resistance(phase_resistance), .tach_output(tach_output));
  escc_host_model #(.DEV_ADDR(BUS_ADDR)) i_escc_host_model (.mclk(mclk), .scl(scl), .sda_drv(sda_drv),
    .sda_in(sda_wire));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Tach pulses are one cycle wide, so each high sample is one pulse
  always @(posedge mclk) begin
    if (tach_output === 1'b1) tach_cnt <= tach_cnt + 1;
  end
  task automatic finish_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_escc_host_model.write_reg(a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    i_escc_host_model.read_reg(a, rd);
    check(rd, exp);
  endtask
  // Bounded poll; an operation that never ends closes the run
  task automatic wait_ready();
    rd = 16'h0000;
    for (int k = 0; k < 20 && rd !== 16'h0001; k++) begin
      i_escc_host_model.read_reg(A_READY, rd);
    end
    if (rd !== 16'h0001) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic cfg_chk(input logic [15:0] w);
    check({14'h0, spread_spectrum_select}, {14'h0, w[15:14]});
    check({15'h0, cycle_adjust_select}, {15'h0, w[7]});
    check({5'h00, phase_resistance}, {5'h00, {7'h00, w[3:0]} << w[6:4]});
  endtask
  task automatic tach_run(input logic [15:0] w, input int n, input logic cl, input int exp);
    int base;
    wr(A_CFG_FIRST, w);
    base = tach_cnt;
    closed_loop <= cl;
    repeat (n) begin
      @(posedge mclk) elec_pulse <= 1'b1;
      @(posedge mclk) elec_pulse <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    check(16'(tach_cnt - base), 16'(exp));
  endtask
  initial begin
    rst_n = 1'b0;
    elec_pulse = 1'b0;
    closed_loop = 1'b0;
    num_errors = 0;
    n_tests = 0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    cfg_chk(16'h0000);
    rd_chk(A_IND_RDATA, 16'h0000);
    // Inhibit held through all programming below
    wr(A_CTRL, 16'h8000);
    check({15'h0, motor_drive_inhibit}, 16'h0001);
    rd_chk(A_CTRL, 16'h0000);
    foreach (unused_a[i]) begin
      wr(unused_a[i], 16'hffff);
      rd_chk(unused_a[i], 16'h0000);
    end
    // Shadow words stay inactive until shadow use is set
    wr(A_CFG_FIRST, 16'h45af);
    cfg_chk(16'h0000);
    rd_chk(A_CFG_FIRST, 16'h0000);
    wr(A_ACC_CTRL, 16'h1000);
    rd_chk(A_ACC_CTRL, 16'h1000);
    foreach (cfg_w[i]) begin
      wr(A_CFG_FIRST, cfg_w[i]);
      cfg_chk(cfg_w[i]);
      rd_chk(A_CFG_FIRST, cfg_w[i]);
    end
    tach_run(16'h1200, 6, 1'b1, 2);
    tach_run(16'h1200, 6, 1'b0, 0);
    tach_run(16'h2000, 2, 1'b0, 0);
    tach_run(16'h0000, 3, 1'b0, 3);
    // Single write then read back through the address register
    wr(A_KEY, UNLOCK_KEY);
    wr(A_ACC_CTRL, 16'h1001);
    wr(A_IND_ADDR, 16'h0090);
    wait_ready();
    wr(A_IND_WDATA, 16'h1238);
    wait_ready();
    wr(A_IND_ADDR, 16'h0090);
    wait_ready();
    rd_chk(A_IND_RDATA, 16'h1238);
    wr(A_ACC_CTRL, 16'h0000);
    cfg_chk(16'h1238);
    wr(A_IND_WDATA, 16'h5555);
    wait_ready();
    rd_chk(A_CFG_FIRST, 16'h1238);
    // Mass copy, then both reload bits undo a shadow edit
    wr(A_CFG_FIRST, 16'habcd);
    wr(A_ACC_CTRL, 16'h0002);
    wait_ready();
    cfg_chk(16'habcd);
    wr(A_CFG_FIRST, 16'h0f0f);
    wr(A_ACC_CTRL, 16'h1100);
    wait_ready();
    rd_chk(A_ACC_CTRL, 16'h1000);
    rd_chk(A_CFG_FIRST, 16'habcd);
    wr(A_CFG_FIRST, 16'h0f0f);
    wr(A_ACC_CTRL, 16'h1004);
    wait_ready();
    rd_chk(A_CFG_FIRST, 16'habcd);
    cfg_chk(16'habcd);
    wr(A_CTRL, 16'h0000);
    check({15'h0, motor_drive_inhibit}, 16'h0000);
    finish_test();
  end
endmodule
